// >>> dv/pvt_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// power and stream relations at the host ports
module pvt_host_asserts #(
    parameter int unsigned     DATA_W  = 48,
    parameter longint unsigned T12_CYC = 20,
    parameter longint unsigned T3_CYC  = 30,
    parameter longint unsigned T4_CYC  = 15,
    parameter longint unsigned T67_CYC = 25
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              power_req,
    input wire logic [DATA_W-1:0] pix_data,
    input wire logic              pix_req,
    input wire logic              pix_sensor_line,
    input wire logic              pix_line_start,
    input wire logic              pix_frame_start,
    input wire logic [DATA_W-1:0] link_data,
    input wire logic              active_video_qualifier,
    input wire logic              link_pixel_strobe,
    input wire logic              link_oe,
    input wire logic              panel_supply,
    input wire logic              backlight_on_control,
    input wire logic              panel_ready,
    input wire logic [2:0]        power_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // cycles spent in the state left behind
    logic [2:0]  last_state;
    logic [31:0] dwell;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_state <= 3'h0;
            dwell      <= 32'h0000_0000;
        end
        else
        begin
            last_state <= power_state;
            dwell      <= (power_state != last_state) ? 32'h0000_0001
                                                      : dwell + 32'h0000_0001;
        end
    end

    sequence s_up_taken;
        power_state == pvt_pkg::PVT_OFF && power_req;
    endsequence
    sequence s_down_taken;
        power_state == pvt_pkg::PVT_RUN && !power_req;
    endsequence

    a_up_prompt: assert property (s_up_taken |=>
        power_state == pvt_pkg::PVT_RAMP && panel_supply && link_oe)
        else $error("supply not raised");
    a_down_prompt: assert property (s_down_taken |=>
        power_state == pvt_pkg::PVT_DIM && !backlight_on_control
        && !panel_ready)
        else $error("lamp not off first");
    a_oe_supply: assert property (link_oe == panel_supply)
        else $error("drive differs from supply");
    a_off_quiet: assert property (!panel_supply |-> !(|link_data) &&
        !active_video_qualifier && !link_pixel_strobe && !backlight_on_control)
        else $error("output active while supply off");
    a_lamp_run: assert property (backlight_on_control |->
        power_state == pvt_pkg::PVT_RUN && panel_supply)
        else $error("lamp lit outside run");
    a_ramp_time: assert property (power_state == pvt_pkg::PVT_WAKE &&
        last_state == pvt_pkg::PVT_RAMP |-> dwell == T12_CYC)
        else $error("ramp length wrong");
    a_wake_time: assert property (power_state == pvt_pkg::PVT_RUN &&
        last_state == pvt_pkg::PVT_WAKE |-> dwell >= T3_CYC)
        else $error("lamp lit too early");
    a_dim_time: assert property (power_state == pvt_pkg::PVT_QUIET &&
        last_state == pvt_pkg::PVT_DIM |-> dwell >= T4_CYC)
        else $error("video stopped early");
    a_rest_time: assert property (power_state == pvt_pkg::PVT_OFF &&
        last_state == pvt_pkg::PVT_FALL |-> dwell >= T67_CYC)
        else $error("rest too short");
    a_pix_forward: assert property (pix_req |=> link_pixel_strobe &&
        active_video_qualifier && link_data == $past(pix_data))
        else $error("pixel not forwarded");
    a_blank_zero: assert property (link_pixel_strobe
        && !$past(pix_req) |-> !active_video_qualifier && !(|link_data))
        else $error("blank clock carries data");
    a_hold_link: assert property (!link_pixel_strobe && panel_ready |->
        $stable(active_video_qualifier) && $stable(link_data))
        else $error("link moved");
    a_frame_flags: assert property (pix_frame_start |->
        pix_line_start && pix_sensor_line && pix_req)
        else $error("frame flags missing");
endmodule : pvt_host_asserts

bind pvt_host pvt_host_asserts #(
    .DATA_W(DATA_W), .T12_CYC(T12_CYC), .T3_CYC(T3_CYC),
    .T4_CYC(T4_CYC), .T67_CYC(T67_CYC)
) u_chk (
    .clk, .rst_n, .power_req, .pix_data, .pix_req, .pix_sensor_line,
    .pix_line_start, .pix_frame_start, .link_data, .active_video_qualifier,
    .link_pixel_strobe, .link_oe, .panel_supply, .backlight_on_control,
    .panel_ready, .power_state
);
`default_nettype wire

// >>> dv/pvt_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// panel receiver: rows and frames from the qualifier alone
module pvt_panel_model #(
    parameter int unsigned LINE_CLOCKS = 712
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        panel_supply,
    input wire logic        link_pixel_strobe,
    input wire logic        active_video_qualifier,
    output var logic [15:0] run_len,
    output var logic [15:0] line_len,
    output var logic [15:0] lines,
    output var logic [15:0] frames
);
    logic        qual_d;
    logic [15:0] run;
    logic [15:0] span;
    logic [15:0] gap;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n || !panel_supply)
        begin
            {qual_d, run, span, run_len, line_len, lines, frames} <= '0;
            gap <= 16'hffff;
        end
        else if (link_pixel_strobe)
        begin
            qual_d <= active_video_qualifier;
            span   <= span + 16'h0001;
            run <= active_video_qualifier ? run + 16'h0001 : 16'h0000;
            if (!active_video_qualifier && gap != 16'hffff)
                gap <= gap + 16'h0001;
            if (active_video_qualifier && !qual_d)
            begin
                line_len <= span;
                span     <= 16'h0001;
                gap      <= 16'h0000;
                // long gap opens a new frame, sensor rows count as lines
                if (gap > LINE_CLOCKS[15:0])
                begin
                    frames <= frames + 16'h0001;
                    lines  <= 16'h0001;
                end
                else
                    lines <= lines + 16'h0001;
            end
            if (!active_video_qualifier && qual_d)
                run_len <= run;
        end
    end
endmodule : pvt_panel_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int T12 = 20, T3 = 30, T4 = 15, T5 = 5, T67 = 25;
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic        power_req = 1'b0;
    logic [47:0] pix_data  = 48'h0000_0000_0001;
    logic        pix_req, pix_sensor_line, pix_line_start, pix_frame_start;
    logic [47:0] link_data;
    logic        active_video_qualifier, link_pixel_strobe, link_oe;
    logic        panel_supply, backlight_on_control, panel_ready;
    logic [2:0]  power_state;
    logic [15:0] pm_run, pm_line, pm_lines, pm_frames;
    int          err_total = 0;
    int          compares  = 0;
    int          cyc       = 0;

    always #4 clk = ~clk;
    always @(negedge clk) pix_data <= {pix_data[46:0], ~pix_data[47]};

    pvt_host #(.T12_CYC(T12), .T3_CYC(T3), .T4_CYC(T4), .T5_CYC(T5),
        .T67_CYC(T67)) DUT (.clk, .rst_n, .power_req, .pix_data, .pix_req,
        .pix_sensor_line, .pix_line_start, .pix_frame_start, .link_data,
        .active_video_qualifier, .link_pixel_strobe, .link_oe, .panel_supply,
        .backlight_on_control, .panel_ready, .power_state);
    pvt_panel_model u_panel (.clk, .rst_n, .panel_supply, .link_pixel_strobe,
        .active_video_qualifier, .run_len(pm_run), .line_len(pm_line),
        .lines(pm_lines), .frames(pm_frames));

    task automatic complete_run();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_state(input logic [2:0] s, output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (power_state !== s && n < 2000);
    endtask : wait_state

    task automatic t_quiet_outputs();
        check({link_oe, panel_supply, backlight_on_control, panel_ready,
            power_state, active_video_qualifier, link_pixel_strobe, pix_req,
            |link_data}, 0);
    endtask : t_quiet_outputs

    task automatic t_power_and_stream();
        int n, k, row, strobes;
        power_req = 1'b1;
        wait_state(pvt_pkg::PVT_RAMP, n);
        check(n, 1);
        check({panel_supply, link_oe}, 2'b11);
        wait_state(pvt_pkg::PVT_WAKE, n);
        check(n, T12);
        k = 0;
        row = -1;
        strobes = 0;
        while (row < 17 && k < 30000)
        begin
            @(negedge clk);
            k++;
            if (power_state === pvt_pkg::PVT_RUN && panel_ready !== 1'b1)
                check(0, 1);
            if (k == T3 + 2)
                check({backlight_on_control, panel_ready}, 2'b11);
            if (k > 100 && k <= 12600)
                strobes += link_pixel_strobe;
            if (pix_line_start === 1'b1)
            begin
                check(pix_frame_start, row == -1);
                row++;
                check(pix_sensor_line, row < 16);
                if (row >= 2)
                begin
                    check(pm_run, 640);
                    check(pm_line, 712);
                    check(pm_line - pm_run, 72);
                    check(pm_frames, 1);
                    check(pm_lines, row);
                end
            end
        end
        check(strobes >= 7399 && strobes <= 7401, 1);
    endtask : t_power_and_stream

    task automatic t_power_down();
        int n;
        power_req = 1'b0;
        wait_state(pvt_pkg::PVT_DIM, n);
        check({n[7:0], backlight_on_control, panel_supply}, 10'h005);
        wait_state(pvt_pkg::PVT_QUIET, n);
        check(n, T4);
        repeat (3) @(negedge clk);
        check({active_video_qualifier, |link_data, link_oe}, 3'h1);
        wait_state(pvt_pkg::PVT_FALL, n);
        check(n + 3, T5);
        check({panel_supply, link_oe}, 2'b00);
        wait_state(pvt_pkg::PVT_OFF, n);
        check(n, T67);
    endtask : t_power_down

    task automatic t_abort_and_reset();
        int n;
        logic lit;
        power_req = 1'b1;
        wait_state(pvt_pkg::PVT_RAMP, n);
        power_req = 1'b0;
        wait_state(pvt_pkg::PVT_WAKE, n);
        check(n, T12);
        lit = 1'b0;
        n = 0;
        while (power_state !== pvt_pkg::PVT_QUIET && n < 200)
        begin
            @(negedge clk);
            n++;
            lit = lit | backlight_on_control;
        end
        check({lit, power_state}, {1'b0, pvt_pkg::PVT_QUIET});
        power_req = 1'b1;
        wait_state(pvt_pkg::PVT_FALL, n);
        wait_state(pvt_pkg::PVT_OFF, n);
        check(n, T67);
        wait_state(pvt_pkg::PVT_RAMP, n);
        check(n, 1);
        repeat (4) @(negedge clk);
        rst_n = 1'b0;
        power_req = 1'b0;
        @(negedge clk);
        t_quiet_outputs();
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_quiet_outputs();
    endtask : t_abort_and_reset

    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_quiet_outputs();
        t_power_and_stream();
        t_power_down();
        t_abort_and_reset();
        complete_run();
    end
endmodule : testbench
`default_nettype wire

// >>> rtl/pvt_host.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - pixel clock kept between 72.97 and 78.15 MHz, nominally 74 MHz.
// - frames repeat at a nominal 50 Hz with the typical totals.
// - each frame spans 2075 to 2134 line periods, typically 2076.
// - exactly 2064 active lines per frame.
// - the first 16 active lines form the sensor area.
// - each line spans 703 to 732 pixel clocks, typically 712.
// - each active line carries exactly 640 qualified pixel clocks.
// - horizontal blanking is line total minus 640, typically 72.
// - seven power sequence intervals are kept within their limits; default T67_CYC of 75000000 exceeds the 26-bit counter.
// - backlight on only while panel logic runs; off before signals stop.
// - with panel supply off, all interface outputs are low.
// - with panel supply on, every interface output is actively driven.
// - backlight enable line: high lights the lamps, low turns them off.
// - qualifier travels on data pair three, serial bit position 26.
// ====================
// host side: pixel pacing, link output stage and power sequencer
module pvt_host #(
    parameter int unsigned DATA_W      = 48,
    parameter int unsigned PIX_NUM     = 74,
    parameter int unsigned PIX_DEN     = 125,
    parameter int unsigned LINE_TOTAL  = pvt_pkg::LINE_TOTAL_TYP,
    parameter int unsigned FRAME_TOTAL = pvt_pkg::FRAME_TOTAL_TYP,
    parameter longint unsigned T12_CYC = pvt_pkg::T12_CYC,
    parameter longint unsigned T3_CYC  = pvt_pkg::T3_CYC,
    parameter longint unsigned T4_CYC  = pvt_pkg::T4_CYC,
    parameter longint unsigned T5_CYC  = pvt_pkg::T5_CYC,
    parameter longint unsigned T67_CYC = pvt_pkg::T67_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              power_req,
    input  wire logic [DATA_W-1:0] pix_data,
    output var  logic              pix_req,
    output var  logic              pix_sensor_line,
    output var  logic              pix_line_start,
    output var  logic              pix_frame_start,
    output var  logic [DATA_W-1:0] link_data,
    output var  logic              active_video_qualifier,
    output var  logic              link_pixel_strobe,
    output var  logic              link_oe,
    output var  logic              panel_supply,
    output var  logic              backlight_on_control,
    output var  logic              panel_ready,
    output var  logic [2:0]        power_state
);
    localparam int unsigned SW = pvt_pkg::SEQ_W;
    localparam int unsigned AW = pvt_pkg::ACC_W;

    // ====================
    // elaboration checks
    if (PIX_NUM == 0 || PIX_NUM >= PIX_DEN || PIX_DEN >= (1 << (AW - 1)))
    begin : g_bad_ratio
        $error("pixel enable ratio out of range");
    end
    if (longint'(pvt_pkg::CLK_KHZ) * PIX_NUM
            < longint'(pvt_pkg::PIX_KHZ_MIN) * PIX_DEN
        || longint'(pvt_pkg::CLK_KHZ) * PIX_NUM
            > longint'(pvt_pkg::PIX_KHZ_MAX) * PIX_DEN)
    begin : g_bad_rate
        $error("average pixel rate outside the link clock range");
    end
    if (LINE_TOTAL < pvt_pkg::LINE_TOTAL_MIN
        || LINE_TOTAL > pvt_pkg::LINE_TOTAL_MAX)
    begin : g_bad_line
        $error("line total out of range");
    end
    if (FRAME_TOTAL < pvt_pkg::FRAME_TOTAL_MIN
        || FRAME_TOTAL > pvt_pkg::FRAME_TOTAL_MAX
        || FRAME_TOTAL - pvt_pkg::FRAME_ACTIVE_LINES
            < pvt_pkg::FRAME_BLANK_LEAST)
    begin : g_bad_frame
        $error("frame total out of range");
    end
    if (T12_CYC < 1 || T3_CYC < 1 || T4_CYC < 1 || T5_CYC < 4
        || T67_CYC < 1 || T12_CYC >> SW != 0 || T3_CYC >> SW != 0
        || T4_CYC >> SW != 0 || T5_CYC >> SW != 0 || T67_CYC >> SW != 0)
    begin : g_bad_seq
        $error("power sequence count does not fit the counter");
    end
    if (DATA_W < 1)
    begin : g_bad_data
        $error("data width must be positive");
    end

    // ====================
    // state
    typedef struct packed {
        pvt_pkg::pvt_pwr_t st;
        logic [SW-1:0]     cnt;
        logic [AW-1:0]     acc;
        logic              run;
        logic              pix_en;
        logic              emit;
        logic              req;
        logic              sensor;
        logic              lstart;
        logic              fstart;
        logic [DATA_W-1:0] data;
        logic              de;
        logic              strobe;
        logic              oe;
        logic              supply;
        logic              bl;
        logic              ready;
    } pvt_host_state_t;

    pvt_host_state_t s;
    pvt_host_state_t next_s;

    pvt_vt_if vif ();

    // ====================
    // helpers
    function automatic logic [SW-1:0] pvt_load(input longint unsigned cyc);
        return SW'(cyc - 1);
    endfunction : pvt_load

    function automatic logic pvt_video_on(input pvt_pkg::pvt_pwr_t st);
        return (st == pvt_pkg::PVT_WAKE) || (st == pvt_pkg::PVT_RUN)
            || (st == pvt_pkg::PVT_DIM);
    endfunction : pvt_video_on

    // ====================
    // raster counter
    pvt_timing #(
        .LINE_TOTAL  (LINE_TOTAL),
        .FRAME_TOTAL (FRAME_TOTAL)
    ) u_timing (
        .clk   (clk),
        .rst_n (rst_n),
        .vif   (vif.gen)
    );

    assign vif.pix_en = s.pix_en;
    assign vif.run    = s.run;

    // ====================
    // next state
    always_comb
    begin
        next_s = s;

        // fractional divider paces pixels at PIX_NUM/PIX_DEN of clk
        next_s.pix_en = 1'b0;
        if (s.run)
        begin
            if (s.acc + AW'(PIX_NUM) >= AW'(PIX_DEN))
            begin
                next_s.acc    = s.acc + AW'(PIX_NUM) - AW'(PIX_DEN);
                next_s.pix_en = 1'b1;
            end
            else
            begin
                next_s.acc = s.acc + AW'(PIX_NUM);
            end
        end
        else
        begin
            next_s.acc = '0;
        end

        // stage one: ask the user for a pixel on qualified clocks
        next_s.emit   = vif.tick;
        next_s.req    = vif.tick && vif.active;
        next_s.sensor = vif.tick && vif.active && vif.sensor;
        next_s.lstart = vif.tick && vif.line_start;
        next_s.fstart = vif.tick && vif.frame_start;

        // stage two: present one link pixel clock worth of data
        next_s.strobe = s.emit;
        if (s.emit)
        begin
            next_s.de   = s.req;
            next_s.data = s.req ? pix_data : '0;
        end
        if (!s.run && !s.emit)
        begin
            next_s.de   = 1'b0;
            next_s.data = '0;
        end

        // power sequencer
        if (s.cnt != '0)
        begin
            next_s.cnt = s.cnt - SW'(1);
        end
        unique case (s.st)
            pvt_pkg::PVT_OFF:
            begin
                if (power_req)
                begin
                    next_s.st     = pvt_pkg::PVT_RAMP;
                    next_s.cnt    = pvt_load(T12_CYC);
                    next_s.supply = 1'b1;
                    next_s.oe     = 1'b1;
                end
            end
            pvt_pkg::PVT_RAMP:
            begin
                if (s.cnt == '0)
                begin
                    next_s.st  = pvt_pkg::PVT_WAKE;
                    next_s.cnt = pvt_load(T3_CYC);
                    next_s.run = 1'b1;
                end
            end
            pvt_pkg::PVT_WAKE:
            begin
                if (!power_req)
                begin
                    next_s.st  = pvt_pkg::PVT_QUIET;
                    next_s.cnt = pvt_load(T5_CYC);
                    next_s.run = 1'b0;
                end
                else if (s.cnt == '0)
                begin
                    next_s.st    = pvt_pkg::PVT_RUN;
                    next_s.bl    = 1'b1;
                    next_s.ready = 1'b1;
                end
            end
            pvt_pkg::PVT_RUN:
            begin
                if (!power_req)
                begin
                    next_s.st    = pvt_pkg::PVT_DIM;
                    next_s.cnt   = pvt_load(T4_CYC);
                    next_s.bl    = 1'b0;
                    next_s.ready = 1'b0;
                end
            end
            pvt_pkg::PVT_DIM:
            begin
                if (s.cnt == '0)
                begin
                    next_s.st  = pvt_pkg::PVT_QUIET;
                    next_s.cnt = pvt_load(T5_CYC);
                    next_s.run = 1'b0;
                end
            end
            pvt_pkg::PVT_QUIET:
            begin
                if (s.cnt == '0)
                begin
                    next_s.st     = pvt_pkg::PVT_FALL;
                    next_s.cnt    = pvt_load(T67_CYC);
                    next_s.supply = 1'b0;
                    next_s.oe     = 1'b0;
                end
            end
            pvt_pkg::PVT_FALL:
            begin
                if (s.cnt == '0)
                begin
                    next_s.st = pvt_pkg::PVT_OFF;
                end
            end
            default:
            begin
                next_s        = '0;
                next_s.st     = pvt_pkg::PVT_OFF;
            end
        endcase

        // video stops with the sequencer, never outlives it
        if (!pvt_video_on(next_s.st))
        begin
            next_s.run = 1'b0;
        end
    end

    // ====================
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ====================
    // outputs straight from the state register
    assign pix_req                = s.req;
    assign pix_sensor_line        = s.sensor;
    assign pix_line_start         = s.lstart;
    assign pix_frame_start        = s.fstart;
    assign link_data              = s.data;
    assign active_video_qualifier = s.de;
    assign link_pixel_strobe      = s.strobe;
    assign link_oe                = s.oe;
    assign panel_supply           = s.supply;
    assign backlight_on_control   = s.bl;
    assign panel_ready            = s.ready;
    assign power_state            = s.st;

endmodule : pvt_host
`default_nettype wire

// >>> rtl/pvt_pkg.sv
`default_nettype none
// ====================
// panel video timing and power sequencing constants
package pvt_pkg;

    // ====================
    // clock rates in kHz, picture rate in Hz
    localparam int unsigned CLK_KHZ     = 125000;
    localparam int unsigned PIX_KHZ_MIN = 72970;
    localparam int unsigned PIX_KHZ_TYP = 74000;
    localparam int unsigned PIX_KHZ_MAX = 78150;
    localparam int unsigned PICTURE_RATE_NOMINAL_HZ = 50;

    // ====================
    // line timing in pixel clocks
    localparam int unsigned LINE_ACTIVE_CLOCKS = 640;
    localparam int unsigned LINE_TOTAL_MIN     = 703;
    localparam int unsigned LINE_TOTAL_TYP     = 712;
    localparam int unsigned LINE_TOTAL_MAX     = 732;
    localparam int unsigned LINE_BLANK_CLOCKS  = LINE_TOTAL_TYP
                                               - LINE_ACTIVE_CLOCKS;

    // ====================
    // frame timing in line periods
    localparam int unsigned FRAME_ACTIVE_LINES = 2064;
    localparam int unsigned FRAME_TOTAL_MIN    = 2075;
    localparam int unsigned FRAME_TOTAL_TYP    = 2076;
    localparam int unsigned FRAME_TOTAL_MAX    = 2134;
    localparam int unsigned FRAME_BLANK_LINES  = FRAME_TOTAL_TYP
                                               - FRAME_ACTIVE_LINES;
    localparam int unsigned SENSOR_LINES       = 16;
    localparam int unsigned FRAME_BLANK_LEAST  = 2;

    // ====================
    // counter widths
    localparam int unsigned HCNT_W = 10;
    localparam int unsigned VCNT_W = 12;
    localparam int unsigned SEQ_W  = 26;
    localparam int unsigned ACC_W  = 8;

    // ====================
    // power sequence intervals in microseconds
    localparam int unsigned T1_MAX_US = 10000;
    localparam int unsigned T2_SET_US = 1000;
    localparam int unsigned T3_MIN_US = 450000;
    localparam int unsigned T4_MIN_US = 90000;
    localparam int unsigned T5_SET_US = 1000;
    localparam int unsigned T6_MAX_US = 100000;
    localparam int unsigned T7_MIN_US = 500000;

    // least times round up, longest times round down
    localparam longint unsigned T12_CYC =
        (longint'(T1_MAX_US + T2_SET_US) * CLK_KHZ) / 1000;
    localparam longint unsigned T3_CYC =
        (longint'(T3_MIN_US) * CLK_KHZ + 999) / 1000;
    localparam longint unsigned T4_CYC =
        (longint'(T4_MIN_US) * CLK_KHZ + 999) / 1000;
    localparam longint unsigned T5_CYC =
        (longint'(T5_SET_US) * CLK_KHZ) / 1000;
    localparam longint unsigned T67_CYC =
        (longint'(T6_MAX_US + T7_MIN_US) * CLK_KHZ + 999) / 1000;

    // ====================
    // power sequencer states
    typedef enum logic [2:0] {
        PVT_OFF   = 3'h0,
        PVT_RAMP  = 3'h1,
        PVT_WAKE  = 3'h2,
        PVT_RUN   = 3'h3,
        PVT_DIM   = 3'h4,
        PVT_QUIET = 3'h5,
        PVT_FALL  = 3'h6
    } pvt_pwr_t;

endpackage : pvt_pkg
`default_nettype wire

// >>> rtl/pvt_timing.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// raster counter: one step per pixel enable
module pvt_timing #(
    parameter int unsigned LINE_TOTAL  = pvt_pkg::LINE_TOTAL_TYP,
    parameter int unsigned FRAME_TOTAL = pvt_pkg::FRAME_TOTAL_TYP
) (
    input  wire logic clk,
    input  wire logic rst_n,
    pvt_vt_if.gen     vif
);
    localparam int unsigned HW = pvt_pkg::HCNT_W;
    localparam int unsigned VW = pvt_pkg::VCNT_W;

    typedef struct packed {
        logic [HW-1:0] hcnt;
        logic [VW-1:0] vcnt;
        logic          tick;
        logic          active;
        logic          sensor;
        logic          lstart;
        logic          fstart;
    } pvt_tim_state_t;

    pvt_tim_state_t s;
    pvt_tim_state_t next_s;

    logic in_rows;

    // ====================
    // next state
    always_comb
    begin
        next_s        = s;
        next_s.tick   = 1'b0;
        next_s.lstart = 1'b0;
        next_s.fstart = 1'b0;
        in_rows       = s.vcnt < VW'(pvt_pkg::FRAME_ACTIVE_LINES);
        if (!vif.run)
        begin
            next_s = '0;
        end
        else if (vif.pix_en)
        begin
            next_s.tick   = 1'b1;
            // qualifier only on active clocks of active rows
            next_s.active = in_rows
                && (s.hcnt < HW'(pvt_pkg::LINE_ACTIVE_CLOCKS));
            next_s.sensor = s.vcnt < VW'(pvt_pkg::SENSOR_LINES);
            next_s.lstart = in_rows && (s.hcnt == '0);
            next_s.fstart = (s.vcnt == '0) && (s.hcnt == '0);
            if (s.hcnt == HW'(LINE_TOTAL - 1))
            begin
                next_s.hcnt = '0;
                if (s.vcnt == VW'(FRAME_TOTAL - 1))
                begin
                    next_s.vcnt = '0;
                end
                else
                begin
                    next_s.vcnt = s.vcnt + VW'(1);
                end
            end
            else
            begin
                next_s.hcnt = s.hcnt + HW'(1);
            end
        end
    end

    // ====================
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign vif.tick        = s.tick;
    assign vif.active      = s.active;
    assign vif.sensor      = s.sensor;
    assign vif.line_start  = s.lstart;
    assign vif.frame_start = s.fstart;

endmodule : pvt_timing
`default_nettype wire

// >>> rtl/pvt_vt_if.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// pixel pacing and position flags between sequencer and raster counter
interface pvt_vt_if;
    logic pix_en;
    logic run;
    logic tick;
    logic active;
    logic sensor;
    logic line_start;
    logic frame_start;

    modport gen (
        input  pix_en,
        input  run,
        output tick,
        output active,
        output sensor,
        output line_start,
        output frame_start
    );

    modport use_side (
        output pix_en,
        output run,
        input  tick,
        input  active,
        input  sensor,
        input  line_start,
        input  frame_start
    );
endinterface : pvt_vt_if
`default_nettype wire
